// ### verilog/spcc_port.sv
/*
 Per-port configuration and status control for one switch port: speed and
 duplex selection, shutdown, negotiation start, pause, frame size limit,
 excessive collisions, power saving and crossover control.
 Assumes a PCS/PHY beside it that performs the negotiation itself and
 reports link state, resolved speed and the partner's pause bit.
*/
// Contract
// - Disabled speed setting shuts the port down.
// - Forced 10/100 half/full, gigabit full only.
// - Forced ten-gigabit full duplex supported.
// - Auto settings: 1G fiber, 10G fiber, copper.
// - Auto mode: flow enable is advertisement only.
// - Forced mode: flow enable applies directly.
// - Report whether received pause halts transmit.
// - Report whether port transmits pause frames.
// - Auto pause from last completed negotiation.
// - Frame limit incl FCS, copper 9600, fiber 9000.
// - Default: drop frame after 16 collisions.
// - Restart mode: restart backoff after 16.
// - Power saving: none, down, up, both.
// - Forced 10/100 disables crossover detection.
// - Expose link state and current speed.
`timescale 1ns/1ps
module spcc_port #(
    parameter int RESTART_CYCLES = spcc_pkg::RESTART_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Configuration
    input wire logic [3:0] cfg_speed_i,
    input wire logic cfg_fc_en_i,
    input wire logic [13:0] cfg_max_frame_i,
    input wire logic cfg_fiber_i,
    input wire logic cfg_coll_restart_i,
    input wire logic [1:0] cfg_power_i,
    // PHY status
    input wire logic phy_link_up_i,
    input wire logic [2:0] phy_speed_i,
    input wire logic an_done_i,
    input wire logic partner_pause_i,
    // Transmit events
    input wire logic tx_frame_start_i,
    input wire logic tx_collision_i,
    // Receive length check
    input wire logic rx_frame_end_i,
    input wire logic [13:0] rx_frame_len_i,
    // PHY control
    output logic port_enable_o,
    output logic an_enable_o,
    output logic an_restart_o,
    output logic [2:0] force_speed_o,
    output logic full_duplex_forced_o,
    output logic half_duplex_forced_o,
    output logic an_adv_pause_o,
    output logic fiber_10g_o,
    output logic mdix_auto_o,
    output logic link_down_power_save_o,
    output logic link_up_power_save_o,
    // MAC control
    output logic [13:0] max_frame_o,
    output logic rx_oversize_o,
    output logic tx_drop_o,
    output logic tx_backoff_restart_o,
    // Status
    output logic rx_pause_o,
    output logic tx_pause_o,
    output logic link_up_o,
    output logic [2:0] cur_speed_o
);

    typedef enum logic [1:0] {ST_DOWN, ST_RESTART, ST_RUN} spcc_state_t;

    function automatic logic spcc_is_auto(input logic [3:0] s);
        spcc_is_auto = (s == spcc_pkg::SPD_AUTO) ||
            (s == spcc_pkg::SPD_AUTO_FIB1G) ||
            (s == spcc_pkg::SPD_AUTO_FIB10G);
    endfunction

    function automatic logic spcc_is_low(input logic [3:0] s);
        spcc_is_low = (s == spcc_pkg::SPD_10_HDX) ||
            (s == spcc_pkg::SPD_10_FDX) ||
            (s == spcc_pkg::SPD_100_HDX) ||
            (s == spcc_pkg::SPD_100_FDX);
    endfunction

    spcc_state_t state_reg;
    spcc_state_t state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [3:0] spd_reg;
    logic [3:0] spd_next;
    logic fc_reg;
    logic fc_next;
    logic restart_reg;
    logic restart_next;
    logic [2:0] fspd_reg;
    logic [2:0] fspd_next;
    logic fdx_reg;
    logic fdx_next;
    logic hdx_reg;
    logic hdx_next;
    logic mdix_reg;
    logic mdix_next;
    logic [13:0] maxf_reg;
    logic [13:0] maxf_next;
    logic ovs_reg;
    logic ovs_next;
    logic ldps_reg;
    logic ldps_next;
    logic lups_reg;
    logic lups_next;
    logic link_reg;
    logic link_next;
    logic [2:0] cur_reg;
    logic [2:0] cur_next;
    logic [13:0] fmax;
    logic cfg_change;
    logic is_auto;

    assign is_auto = spcc_is_auto(spd_reg);
    assign cfg_change = (cfg_speed_i != spd_reg) || (cfg_fc_en_i != fc_reg);
    assign fmax = cfg_fiber_i ? spcc_pkg::FRAME_MAX_FIBER
        : spcc_pkg::FRAME_MAX_COPPER;

    // Link control state machine
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        spd_next = cfg_speed_i;
        fc_next = cfg_fc_en_i;
        restart_next = 1'b0;
        case (state_reg)
            ST_DOWN: begin
                if (cfg_speed_i != spcc_pkg::SPD_DISABLE) begin
                    state_next = ST_RESTART;
                    cnt_next = 16'h0000;
                end
            end
            ST_RESTART: begin
                // Hold link down long enough for the partner to notice
                if (cfg_speed_i == spcc_pkg::SPD_DISABLE) begin
                    state_next = ST_DOWN;
                end else if (cfg_change) begin
                    cnt_next = 16'h0000;
                end else if (cnt_reg == 16'(RESTART_CYCLES - 1)) begin
                    state_next = ST_RUN;
                    restart_next = spcc_is_auto(cfg_speed_i);
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
            ST_RUN: begin
                if (cfg_speed_i == spcc_pkg::SPD_DISABLE) begin
                    state_next = ST_DOWN;
                end else if (cfg_change) begin
                    state_next = ST_RESTART;
                    cnt_next = 16'h0000;
                end
            end
            default: state_next = ST_DOWN;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ST_DOWN;
            cnt_reg <= 16'h0000;
            spd_reg <= spcc_pkg::SPD_DISABLE;
            fc_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            spd_reg <= spd_next;
            fc_reg <= fc_next;
            restart_reg <= restart_next;
        end
    end

    // Forced speed, duplex and crossover decode
    always_comb begin
        fspd_next = spcc_pkg::CUR_DOWN;
        fdx_next = 1'b0;
        hdx_next = 1'b0;
        mdix_next = ~spcc_is_low(cfg_speed_i);
        case (cfg_speed_i)
            spcc_pkg::SPD_10_HDX: begin
                fspd_next = spcc_pkg::CUR_10M;
                hdx_next = 1'b1;
            end
            spcc_pkg::SPD_10_FDX: begin
                fspd_next = spcc_pkg::CUR_10M;
                fdx_next = 1'b1;
            end
            spcc_pkg::SPD_100_HDX: begin
                fspd_next = spcc_pkg::CUR_100M;
                hdx_next = 1'b1;
            end
            spcc_pkg::SPD_100_FDX: begin
                fspd_next = spcc_pkg::CUR_100M;
                fdx_next = 1'b1;
            end
            spcc_pkg::SPD_1G_FDX: begin
                fspd_next = spcc_pkg::CUR_1G;
                fdx_next = 1'b1;
            end
            spcc_pkg::SPD_10G_FDX: begin
                fspd_next = spcc_pkg::CUR_10G;
                fdx_next = 1'b1;
            end
            default: fspd_next = spcc_pkg::CUR_DOWN;
        endcase
    end

    // Frame limit, power saving and status
    always_comb begin
        maxf_next = maxf_reg;
        // Out-of-range request is clamped, not ignored
        if (cfg_max_frame_i < spcc_pkg::FRAME_MIN) begin
            maxf_next = spcc_pkg::FRAME_MIN;
        end else if (cfg_max_frame_i > fmax) begin
            maxf_next = fmax;
        end else begin
            maxf_next = cfg_max_frame_i;
        end
        ovs_next = rx_frame_end_i && (rx_frame_len_i > maxf_reg);
        ldps_next = (cfg_power_i == spcc_pkg::PWR_DOWN_ONLY) ||
            (cfg_power_i == spcc_pkg::PWR_BOTH);
        lups_next = (cfg_power_i == spcc_pkg::PWR_UP_ONLY) ||
            (cfg_power_i == spcc_pkg::PWR_BOTH);
        link_next = phy_link_up_i && (state_reg == ST_RUN);
        cur_next = link_next ? phy_speed_i : spcc_pkg::CUR_DOWN;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fspd_reg <= spcc_pkg::CUR_DOWN;
            fdx_reg <= 1'b0;
            hdx_reg <= 1'b0;
            mdix_reg <= 1'b1;
            maxf_reg <= spcc_pkg::FRAME_MIN;
            ovs_reg <= 1'b0;
            ldps_reg <= 1'b0;
            lups_reg <= 1'b0;
            link_reg <= 1'b0;
            cur_reg <= spcc_pkg::CUR_DOWN;
        end else if (ce_i) begin
            fspd_reg <= fspd_next;
            fdx_reg <= fdx_next;
            hdx_reg <= hdx_next;
            mdix_reg <= mdix_next;
            maxf_reg <= maxf_next;
            ovs_reg <= ovs_next;
            ldps_reg <= ldps_next;
            lups_reg <= lups_next;
            link_reg <= link_next;
            cur_reg <= cur_next;
        end
    end

    spcc_pause u_pause (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .auto_i(is_auto),
        .fc_en_i(fc_reg),
        .an_done_i(an_done_i),
        .partner_pause_i(partner_pause_i),
        .rx_pause_o(rx_pause_o),
        .tx_pause_o(tx_pause_o)
    );

    spcc_coll u_coll (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .restart_mode_i(cfg_coll_restart_i),
        .frame_start_i(tx_frame_start_i),
        .collision_i(tx_collision_i),
        .drop_o(tx_drop_o),
        .backoff_restart_o(tx_backoff_restart_o)
    );

    assign port_enable_o = (state_reg == ST_RUN);
    assign an_enable_o = port_enable_o && is_auto;
    assign an_restart_o = restart_reg;
    assign an_adv_pause_o = is_auto && fc_reg;
    assign fiber_10g_o = (spd_reg == spcc_pkg::SPD_AUTO_FIB10G) ||
        (spd_reg == spcc_pkg::SPD_10G_FDX);
    assign force_speed_o = fspd_reg;
    assign full_duplex_forced_o = fdx_reg;
    assign half_duplex_forced_o = hdx_reg;
    assign mdix_auto_o = mdix_reg;
    assign link_down_power_save_o = ldps_reg;
    assign link_up_power_save_o = lups_reg;
    assign max_frame_o = maxf_reg;
    assign rx_oversize_o = ovs_reg;
    assign link_up_o = link_reg;
    assign cur_speed_o = cur_reg;

endmodule // spcc_port

// ### verilog/spcc_pkg.sv
/*
 Package for the switch port configuration control block: speed modes,
 power-saving modes, frame limits, collision limit and link timing.
 Assumes one 250 MHz clock domain shared by every user of the package.
*/
package spcc_pkg;

    // Configured speed encodings
    localparam logic [3:0] SPD_DISABLE = 4'h0;
    localparam logic [3:0] SPD_10_HDX = 4'h1;
    localparam logic [3:0] SPD_10_FDX = 4'h2;
    localparam logic [3:0] SPD_100_HDX = 4'h3;
    localparam logic [3:0] SPD_100_FDX = 4'h4;
    localparam logic [3:0] SPD_1G_FDX = 4'h5;
    localparam logic [3:0] SPD_10G_FDX = 4'h6;
    localparam logic [3:0] SPD_AUTO_FIB10G = 4'h7;
    localparam logic [3:0] SPD_AUTO_FIB1G = 4'h8;
    localparam logic [3:0] SPD_AUTO = 4'h9;

    // Current link speed report encodings
    localparam logic [2:0] CUR_DOWN = 3'h0;
    localparam logic [2:0] CUR_10M = 3'h1;
    localparam logic [2:0] CUR_100M = 3'h2;
    localparam logic [2:0] CUR_1G = 3'h3;
    localparam logic [2:0] CUR_10G = 3'h4;

    // Power-saving modes
    localparam logic [1:0] PWR_NONE = 2'h0;
    localparam logic [1:0] PWR_DOWN_ONLY = 2'h1;
    localparam logic [1:0] PWR_UP_ONLY = 2'h2;
    localparam logic [1:0] PWR_BOTH = 2'h3;

    // Frame size limits in bytes, FCS included
    localparam logic [13:0] FRAME_MIN = 14'd1518;
    localparam logic [13:0] FRAME_MAX_COPPER = 14'd9600;
    localparam logic [13:0] FRAME_MAX_FIBER = 14'd9000;

    // Collisions before the excessive-collision action
    localparam logic [4:0] COLL_LIMIT = 5'd16;

    // Link restart hold time
    localparam int CLK_MHZ = 250;
    localparam int RESTART_NS = 1000;
    localparam int RESTART_CYC = (RESTART_NS * CLK_MHZ + 999) / 1000;

endpackage

// ### verilog/spcc_coll.sv
/*
 Excessive-collision counter for the port transmitter: counts collisions
 of the current frame and drops or restarts backoff at the limit.
 Assumes collision and frame-start strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
module spcc_coll (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Control
    input wire logic restart_mode_i,
    input wire logic frame_start_i,
    input wire logic collision_i,
    // Actions
    output logic drop_o,
    output logic backoff_restart_o
);

    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic drop_reg;
    logic drop_next;
    logic rst_reg;
    logic rst_next;

    always_comb begin
        count_next = count_reg;
        drop_next = 1'b0;
        rst_next = 1'b0;
        if (frame_start_i) begin
            count_next = 5'h00;
        end else if (collision_i) begin
            if (count_reg == spcc_pkg::COLL_LIMIT - 5'd1) begin
                count_next = 5'h00;
                // Restart keeps the frame alive with a fresh backoff
                drop_next = ~restart_mode_i;
                rst_next = restart_mode_i;
            end else begin
                count_next = count_reg + 5'd1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_reg <= 5'h00;
            drop_reg <= 1'b0;
            rst_reg <= 1'b0;
        end else if (ce_i) begin
            count_reg <= count_next;
            drop_reg <= drop_next;
            rst_reg <= rst_next;
        end
    end

    assign drop_o = drop_reg;
    assign backoff_restart_o = rst_reg;

endmodule // spcc_coll

// ### verilog/spcc_pause.sv
/*
 Pause resolution: forced speeds apply the enable directly, automatic
 speeds resolve from own advertisement and the partner's.
 Assumes negotiation results arrive with a one-cycle done pulse.
*/
`timescale 1ns/1ps
module spcc_pause (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Configuration
    input wire logic auto_i,
    input wire logic fc_en_i,
    // Negotiation result
    input wire logic an_done_i,
    input wire logic partner_pause_i,
    // Operating state
    output logic rx_pause_o,
    output logic tx_pause_o
);

    logic rx_reg;
    logic rx_next;
    logic tx_reg;
    logic tx_next;

    always_comb begin
        rx_next = rx_reg;
        tx_next = tx_reg;
        if (!auto_i) begin
            rx_next = fc_en_i;
            tx_next = fc_en_i;
        end else if (an_done_i) begin
            // Symmetric pause only: both ends must advertise
            rx_next = fc_en_i & partner_pause_i;
            tx_next = fc_en_i & partner_pause_i;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_reg <= 1'b0;
            tx_reg <= 1'b0;
        end else if (ce_i) begin
            rx_reg <= rx_next;
            tx_reg <= tx_next;
        end
    end

    assign rx_pause_o = rx_reg;
    assign tx_pause_o = tx_reg;

endmodule // spcc_pause

// ### verif/spcc_port_checker.sv
/*
 Concurrent checks on the spcc_port ports, bound into every instance.
 Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module spcc_port_checker #(
    parameter int RESTART_CYCLES = 4
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Configuration and events
    input wire logic [3:0] cfg_speed_i,
    input wire logic cfg_fc_en_i,
    input wire logic cfg_coll_restart_i,
    input wire logic [1:0] cfg_power_i,
    input wire logic phy_link_up_i,
    input wire logic an_done_i,
    input wire logic partner_pause_i,
    input wire logic tx_collision_i,
    input wire logic rx_frame_end_i,
    input wire logic [13:0] rx_frame_len_i,
    // Watched outputs
    input wire logic port_enable_o,
    input wire logic an_enable_o,
    input wire logic an_restart_o,
    input wire logic [2:0] force_speed_o,
    input wire logic full_duplex_forced_o,
    input wire logic half_duplex_forced_o,
    input wire logic an_adv_pause_o,
    input wire logic mdix_auto_o,
    input wire logic link_down_power_save_o,
    input wire logic link_up_power_save_o,
    input wire logic [13:0] max_frame_o,
    input wire logic rx_oversize_o,
    input wire logic tx_drop_o,
    input wire logic tx_backoff_restart_o,
    input wire logic rx_pause_o,
    input wire logic tx_pause_o,
    input wire logic link_up_o
);
    logic [7:0] dn_cnt_reg;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Saturates so a long shutdown cannot wrap
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dn_cnt_reg <= 8'h00;
        end else if (port_enable_o) begin
            dn_cnt_reg <= 8'h00;
        end else if (dn_cnt_reg != 8'hff) begin
            dn_cnt_reg <= dn_cnt_reg + 8'h01;
        end
    end

    AST_DISABLE: assert property (ce_i && cfg_speed_i == 4'h0 |=>
        !port_enable_o && !an_enable_o) else $error("port up while disabled");
    AST_FORCED_1G: assert property (ce_i && cfg_speed_i == 4'h5 |=>
        force_speed_o == 3'h3 && full_duplex_forced_o && !half_duplex_forced_o)
        else $error("gigabit decode wrong");
    AST_FORCED_10G: assert property (ce_i && cfg_speed_i == 4'h6 |=>
        force_speed_o == 3'h4 && full_duplex_forced_o && !an_enable_o)
        else $error("ten gigabit decode wrong");
    AST_MDIX: assert property (ce_i && cfg_speed_i inside {[4'h1:4'h4]}
        |=> !mdix_auto_o) else $error("crossover left on");
    AST_ADV: assert property (ce_i && cfg_speed_i == 4'h9 |=>
        an_adv_pause_o == $past(cfg_fc_en_i)) else $error("advert wrong");
    AST_FORCED_PAUSE: assert property ((ce_i && $stable(cfg_fc_en_i) &&
        cfg_speed_i inside {[4'h1:4'h6]}) [*3] |-> rx_pause_o == cfg_fc_en_i
        && tx_pause_o == cfg_fc_en_i) else $error("forced pause wrong");
    AST_AUTO_PAUSE: assert property (ce_i && $past(ce_i) && an_done_i &&
        cfg_speed_i inside {[4'h7:4'h9]} && $stable(cfg_speed_i) &&
        $stable(cfg_fc_en_i) |=> rx_pause_o == $past(cfg_fc_en_i &&
        partner_pause_i) && tx_pause_o == rx_pause_o)
        else $error("resolved pause wrong");
    AST_DROP: assert property (tx_drop_o |->
        $past(tx_collision_i) && !$past(cfg_coll_restart_i))
        else $error("drop without collision");
    AST_BACKOFF: assert property (tx_backoff_restart_o |->
        $past(tx_collision_i) && $past(cfg_coll_restart_i))
        else $error("backoff restart without collision");
    AST_OVERSIZE: assert property (ce_i && rx_frame_end_i |=>
        rx_oversize_o == $past(rx_frame_len_i > max_frame_o))
        else $error("oversize flag wrong");
    AST_POWER: assert property (ce_i |=>
        link_down_power_save_o == $past(cfg_power_i[0]) &&
        link_up_power_save_o == $past(cfg_power_i[1]))
        else $error("power mode wrong");
    AST_LINK: assert property (ce_i |=>
        link_up_o == $past(phy_link_up_i && port_enable_o))
        else $error("link state wrong");
    AST_RESTART_HOLD: assert property ($rose(port_enable_o) |->
        int'(dn_cnt_reg) >= RESTART_CYCLES) else $error("restart too short");
    AST_AN_RESTART: assert property ($rose(port_enable_o) |->
        an_restart_o == an_enable_o) else $error("negotiation restart wrong");

    COV_DROP: cover property (tx_drop_o);
    COV_BACKOFF: cover property (tx_backoff_restart_o);
    COV_OVERSIZE: cover property (rx_oversize_o);
    COV_AUTO_PAUSE: cover property (rx_pause_o && an_enable_o);
endmodule // spcc_port_checker

bind spcc_port spcc_port_checker #(.RESTART_CYCLES(RESTART_CYCLES)) chk_inst (
    .mclk_i, .arst_n_i, .ce_i, .cfg_speed_i, .cfg_fc_en_i, .cfg_coll_restart_i,
    .cfg_power_i, .phy_link_up_i, .an_done_i, .partner_pause_i, .tx_collision_i,
    .rx_frame_end_i, .rx_frame_len_i, .port_enable_o, .an_enable_o,
    .force_speed_o, .full_duplex_forced_o, .half_duplex_forced_o,
    .an_adv_pause_o, .mdix_auto_o, .link_down_power_save_o, .an_restart_o,
    .link_up_power_save_o, .max_frame_o, .rx_oversize_o, .tx_drop_o,
    .tx_backoff_restart_o, .rx_pause_o, .tx_pause_o, .link_up_o);

// ### verif/spcc_link_partner.sv
/*
 Behavioural link partner with its PHY: raises link a few cycles after
 the port is enabled and reports negotiation with a done pulse.
 Assumes the bench sets the partner's pause ability and its pace.
*/
`timescale 1ns/1ps
module spcc_link_partner (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // From the port
    input wire logic port_enable_i,
    input wire logic an_enable_i,
    input wire logic an_restart_i,
    input wire logic [2:0] force_speed_i,
    // Bench controls
    input wire logic pause_cap_i,
    input wire logic slow_i,
    // Link status
    output logic link_up_o,
    output logic [2:0] speed_o,
    output logic an_done_o,
    output logic pause_o
);
    logic [7:0] cnt_reg;

    // Pause bit only meaningful with done; inverted otherwise
    assign pause_o = an_done_o ? pause_cap_i : ~pause_cap_i;
    assign speed_o = !link_up_o ? 3'h0 : (an_enable_i ? 3'h3 : force_speed_i);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 8'h00;
            link_up_o <= 1'b0;
            an_done_o <= 1'b0;
        end else begin
            an_done_o <= 1'b0;
            if (!port_enable_i || an_restart_i) begin
                cnt_reg <= 8'h00;
                link_up_o <= 1'b0;
            end else if (!link_up_o) begin
                cnt_reg <= cnt_reg + 8'h01;
                if (cnt_reg == (slow_i ? 8'h14 : 8'h02)) begin
                    link_up_o <= 1'b1;
                    an_done_o <= an_enable_i;
                end
            end
        end
    end
endmodule // spcc_link_partner

// ### verif/tb.sv
/*
 Self-checking bench for spcc_port with a behavioural link partner.
 Assumes a 250 MHz clock and a shortened restart count.
*/
`timescale 1ns/1ps
module tb;
    localparam int RC = 4;
    // Forced decode: speed, full, half, crossover
    localparam logic [5:0] DEC [1:6] = '{6'h0a, 6'h0c, 6'h12, 6'h14, 6'h1d,
        6'h25};
    localparam logic [14:0] FR_IN [6] = '{15'h0064, 15'h2581, 15'h6580,
        15'h2580, 15'h6328, 15'h05ee};
    localparam logic [13:0] FR_EXP [6] = '{14'h05ee, 14'h2580, 14'h2328,
        14'h2580, 14'h2328, 14'h05ee};
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [3:0] cfg_speed_i = 4'h0;
    logic cfg_fc_en_i = 1'b0;
    logic [13:0] cfg_max_frame_i = 14'h05ee;
    logic cfg_fiber_i = 1'b0;
    logic cfg_coll_restart_i = 1'b0;
    logic [1:0] cfg_power_i = 2'h0;
    logic tx_frame_start_i = 1'b0;
    logic tx_collision_i = 1'b0;
    logic rx_frame_end_i = 1'b0;
    logic [13:0] rx_frame_len_i = 14'h0000;
    logic cap = 1'b0, slow = 1'b0;
    logic phy_link_up_i, an_done_i, partner_pause_i, port_enable_o;
    logic an_enable_o, an_restart_o, full_duplex_forced_o, half_duplex_forced_o;
    logic an_adv_pause_o, fiber_10g_o, mdix_auto_o, link_down_power_save_o;
    logic link_up_power_save_o, rx_oversize_o, tx_drop_o, tx_backoff_restart_o;
    logic rx_pause_o, tx_pause_o, link_up_o;
    logic [2:0] force_speed_o, cur_speed_o, phy_speed_i;
    logic [13:0] max_frame_o;
    logic [2:0] exp_q[$];
    integer errors = 0, n_compared = 0;
    integer seed = 28459;
    int i, k;

    spcc_port #(.RESTART_CYCLES(RC)) spcc_port_inst (.mclk_i, .arst_n_i, .ce_i,
        .cfg_speed_i, .cfg_fc_en_i, .cfg_max_frame_i, .cfg_fiber_i,
        .cfg_coll_restart_i, .cfg_power_i, .phy_link_up_i, .phy_speed_i,
        .an_done_i, .partner_pause_i, .tx_frame_start_i, .tx_collision_i,
        .rx_frame_end_i, .rx_frame_len_i, .port_enable_o, .an_enable_o,
        .an_restart_o, .force_speed_o, .full_duplex_forced_o,
        .half_duplex_forced_o, .an_adv_pause_o, .fiber_10g_o, .mdix_auto_o,
        .link_down_power_save_o, .link_up_power_save_o, .max_frame_o,
        .rx_oversize_o, .tx_drop_o, .tx_backoff_restart_o, .rx_pause_o,
        .tx_pause_o, .link_up_o, .cur_speed_o);

    spcc_link_partner spcc_link_partner_inst (.mclk_i, .arst_n_i,
        .port_enable_i(port_enable_o), .an_enable_i(an_enable_o),
        .an_restart_i(an_restart_o), .force_speed_i(force_speed_o),
        .pause_cap_i(cap), .slow_i(slow), .link_up_o(phy_link_up_i),
        .speed_o(phy_speed_i), .an_done_o(an_done_i), .pause_o(partner_pause_i));

    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pulse(input logic [2:0] got, input logic [2:0] exp);
        chk({13'h0000, got}, {13'h0000, exp});
    endtask

    task automatic wait_link();
        i = 0;
        while (link_up_o !== 1'b1 && i < 60) begin
            step(1);
            i++;
        end
        chk(16'(i < 60), 16'h0001);
        step(2);
    endtask

    // Frame end stays high across calls; lowered by the caller
    task automatic send_rx(input logic [13:0] len, input logic [13:0] lim);
        rx_frame_len_i = len;
        rx_frame_end_i = 1'b1;
        if (len > lim) exp_q.push_back(3'h4);
        step(1);
    endtask

    task automatic coll(input int n);
        tx_collision_i = 1'b1;
        step(n);
        tx_collision_i = 1'b0;
    endtask

    task automatic end_of_test();
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Result pulses are matched in order against the driver's notes
    always @(posedge mclk_i) begin
        #2;
        if ({rx_oversize_o, tx_backoff_restart_o, tx_drop_o} !== 3'h0) begin
            chk_pulse({rx_oversize_o, tx_backoff_restart_o, tx_drop_o},
                exp_q.size() > 0 ? exp_q.pop_front() : 3'h0);
        end
    end

    initial begin
        #100000;
        errors++;
        end_of_test();
    end

    initial begin
        step(20);
        chk({mdix_auto_o, port_enable_o, max_frame_o}, 16'h85ee);
        arst_n_i = 1'b1;
        step(2);
        for (k = 1; k <= 6; k++) begin
            cfg_speed_i = 4'(k);
            cfg_fc_en_i = 1'($random(seed));
            step(3);
            chk({force_speed_o, full_duplex_forced_o, half_duplex_forced_o,
                mdix_auto_o, an_enable_o}, {DEC[k], 1'b0});
            wait_link();
            chk({cur_speed_o, rx_pause_o, tx_pause_o},
                {DEC[k][5:3], {2{cfg_fc_en_i}}});
        end
        cfg_speed_i = 4'h0;
        step(3);
        chk({port_enable_o, link_up_o, cur_speed_o}, 16'h0000);
        for (k = 7; k <= 9; k++) begin
            cfg_speed_i = 4'(k);
            cfg_fc_en_i = (k != 8);
            cap = (k != 9);
            slow = (k == 8);
            step(3);
            wait_link();
            chk({an_enable_o, an_adv_pause_o, fiber_10g_o, rx_pause_o, tx_pause_o,
                cur_speed_o}, {1'b1, cfg_fc_en_i, {3{k == 7}}, 3'h3});
        end
        cap = 1'b1;
        cfg_fc_en_i = 1'b0;
        step(2);
        chk(16'(port_enable_o), 16'h0000);
        cfg_fc_en_i = 1'b1;
        wait_link();
        chk({rx_pause_o, tx_pause_o}, 16'h0003);
        ce_i = 1'b0;
        cfg_power_i = 2'h3;
        step(3);
        chk({link_up_power_save_o, link_down_power_save_o}, 16'h0000);
        ce_i = 1'b1;
        for (k = 0; k < 4; k++) begin
            cfg_power_i = 2'(k);
            step(2);
            chk({link_up_power_save_o, link_down_power_save_o}, 16'(k));
        end
        for (k = 0; k < 6; k++) begin
            {cfg_fiber_i, cfg_max_frame_i} = FR_IN[k];
            step(2);
            chk(max_frame_o, FR_EXP[k]);
            send_rx(FR_EXP[k], FR_EXP[k]);
            send_rx(FR_EXP[k] + 14'h0001, FR_EXP[k]);
            send_rx(14'($random(seed)), FR_EXP[k]);
            rx_frame_end_i = 1'b0;
            step(2);
        end
        for (k = 0; k < 2; k++) begin
            cfg_coll_restart_i = k[0];
            tx_frame_start_i = 1'b1;
            step(1);
            tx_frame_start_i = 1'b0;
            coll(15);
            tx_frame_start_i = 1'b1;
            step(1);
            tx_frame_start_i = 1'b0;
            exp_q.push_back(k[0] ? 3'h2 : 3'h1);
            coll(16);
            step(3);
        end
        chk(16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule // tb
